// >>> hw/lin_header_control_and_frame_timer.sv
// LIN header control, break sender, auto sync and frame/idle timer
`timescale 1ns/1ps
module lin_header_control_and_frame_timer (
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RESET_N,
	// ahb-lite slave
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic [31:0] O_HRDATA,
	// uart path side
	input wire logic I_BAUD_TICK,
	input wire logic I_RX_PIN,
	input wire lin_hdr_pkg::sync_meas_t I_SYNC,
	output logic O_TX_OVERRIDE,
	output logic O_TX_LEVEL,
	output logic [15:0] O_RATE_DIVISOR,
	// event flags
	output logic O_LIMIT_HIT,
	output logic O_SYNC_RECEIVED,
	output logic O_SYNC_DONE
);

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic ph_write;
	logic ph_valid;
	logic [17:0] ph_index;
	wire take = I_HSEL && I_HREADY && (I_HTRANS == lin_hdr_pkg::HTRANS_NONSEQ);
	wire [17:0] a_index = I_HADDR[19:2];
	wire wr_now = ph_valid && ph_write;
	wire wr_ctrl = wr_now && (ph_index == lin_hdr_pkg::IDX_CONTROL);
	wire wr_thi = wr_now && (ph_index == lin_hdr_pkg::IDX_TIMER_HIGH);
	wire wr_tlo = wr_now && (ph_index == lin_hdr_pkg::IDX_TIMER_LOW);
	wire wr_rate = wr_now && (ph_index == lin_hdr_pkg::IDX_RATE);
	wire wr_flags = wr_now && (ph_index == lin_hdr_pkg::IDX_FLAGS);
	wire [7:0] wd = I_HWDATA[7:0];

	assign O_HREADYOUT = 1'b1;
	assign O_HRESP = 1'b0;

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_index <= '0;
		end else begin
			ph_valid <= take;
			ph_write <= I_HWRITE;
			ph_index <= a_index;
		end
	end

	// ---------------------------------------------------------------
	// rx synchroniser and edge
	// ---------------------------------------------------------------
	logic rx_q1;
	logic rx_q2;
	logic rx_q3;
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rx_q1 <= 1'b1;
			rx_q2 <= 1'b1;
			rx_q3 <= 1'b1;
		end else begin
			rx_q1 <= I_RX_PIN;
			rx_q2 <= rx_q1;
			rx_q3 <= rx_q2;
		end
	end
	wire rx_edge = rx_q2 ^ rx_q3;

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	lin_hdr_pkg::control_t ctrl;
	lin_hdr_pkg::control_t next_ctrl;
	lin_hdr_pkg::brk_state_t brk_state;
	lin_hdr_pkg::brk_state_t next_brk_state;
	logic [4:0] brk_cnt;
	logic [15:0] measured_rate_divisor;
	logic [15:0] rate_divisor;
	logic [15:0] frame_idle_counter;
	logic [15:0] counter_limit;
	logic counter_limit_hit;
	logic sync_received_irq;
	logic auto_sync_done_irq;
	logic hit_prev;

	wire on = ctrl.func_on;
	wire slave_sync = on && !ctrl.master && I_SYNC.valid;
	wire auto_upd = slave_sync && (ctrl.async_always || ctrl.async_once);
	wire [4:0] brk_len = lin_hdr_pkg::BREAK_BASE_BITS + {2'b00, ctrl.extra_len};
	wire brk_start = (brk_state == lin_hdr_pkg::BRK_ALIGN) && I_BAUD_TICK && on;
	wire brk_done = (brk_state == lin_hdr_pkg::BRK_DELIMIT) && I_BAUD_TICK;
	wire new_on = wd[lin_hdr_pkg::BIT_FUNC_ON];
	wire new_master = on ? ctrl.master : wd[lin_hdr_pkg::BIT_MASTER];
	wire brk_set = wr_ctrl && wd[lin_hdr_pkg::BIT_BREAK_REQ] && new_on && new_master;

	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl.func_on = new_on;
			next_ctrl.master = new_master;
			next_ctrl.async_always = wd[lin_hdr_pkg::BIT_ASYNC_ALWAYS];
			next_ctrl.async_once = wd[lin_hdr_pkg::BIT_ASYNC_ONCE];
			next_ctrl.extra_len = wd[lin_hdr_pkg::BIT_EXTRA_HI:0];
		end
		// one-shot consumed by the update it enabled
		if (auto_upd && !ctrl.async_always) begin
			next_ctrl.async_once = 1'b0;
		end
		// writes of zero to the break bit never clear a running break; a write clearing func_on does
		if (brk_done) begin
			next_ctrl.break_req = 1'b0;
		end
		if (brk_set) begin
			next_ctrl.break_req = 1'b1;
		end
		if (!next_ctrl.func_on) begin
			next_ctrl.break_req = 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl <= lin_hdr_pkg::RST_CONTROL;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ---------------------------------------------------------------
	// break sender
	// ---------------------------------------------------------------
	always_comb begin
		next_brk_state = brk_state;
		case (brk_state)
			lin_hdr_pkg::BRK_IDLE: begin
				if (ctrl.break_req) begin
					next_brk_state = lin_hdr_pkg::BRK_ALIGN;
				end
			end
			lin_hdr_pkg::BRK_ALIGN: begin
				if (I_BAUD_TICK) begin
					next_brk_state = lin_hdr_pkg::BRK_DOMINANT;
				end
			end
			lin_hdr_pkg::BRK_DOMINANT: begin
				if (I_BAUD_TICK && (brk_cnt == brk_len - 5'h01)) begin
					next_brk_state = lin_hdr_pkg::BRK_DELIMIT;
				end
			end
			lin_hdr_pkg::BRK_DELIMIT: begin
				if (I_BAUD_TICK) begin
					next_brk_state = lin_hdr_pkg::BRK_IDLE;
				end
			end
			default: next_brk_state = lin_hdr_pkg::BRK_IDLE;
		endcase
		if (!on) begin
			next_brk_state = lin_hdr_pkg::BRK_IDLE;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			brk_state <= lin_hdr_pkg::BRK_IDLE;
			brk_cnt <= '0;
		end else begin
			brk_state <= next_brk_state;
			if (brk_state != lin_hdr_pkg::BRK_DOMINANT) begin
				brk_cnt <= '0;
			end else if (I_BAUD_TICK) begin
				brk_cnt <= brk_cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_TX_OVERRIDE <= 1'b0;
			O_TX_LEVEL <= 1'b1;
		end else begin
			O_TX_OVERRIDE <= (next_brk_state == lin_hdr_pkg::BRK_DOMINANT)
				|| (next_brk_state == lin_hdr_pkg::BRK_DELIMIT);
			O_TX_LEVEL <= next_brk_state != lin_hdr_pkg::BRK_DOMINANT;
		end
	end

	// ---------------------------------------------------------------
	// divisors and sync
	// ---------------------------------------------------------------
	// operating rate is clock / (divisor + 1), divided in the uart path
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			measured_rate_divisor <= lin_hdr_pkg::RST_RATE;
			rate_divisor <= lin_hdr_pkg::RST_RATE;
		end else begin
			if (slave_sync) begin
				measured_rate_divisor <= I_SYNC.divisor;
			end
			if (auto_upd) begin
				rate_divisor <= I_SYNC.divisor;
			end else if (wr_rate) begin
				rate_divisor <= I_HWDATA[15:0];
			end
		end
	end
	assign O_RATE_DIVISOR = rate_divisor;

	// ---------------------------------------------------------------
	// frame / idle timer
	// ---------------------------------------------------------------
	wire cnt_clear = ctrl.master ? brk_start : rx_edge;
	wire hit_cond = on && (ctrl.master ? (frame_idle_counter >= counter_limit)
		: (frame_idle_counter == counter_limit));
	wire hit_evt = hit_cond && !hit_prev;

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			frame_idle_counter <= {lin_hdr_pkg::RST_TIMER_BYTE, lin_hdr_pkg::RST_TIMER_BYTE};
			counter_limit <= {lin_hdr_pkg::RST_TIMER_BYTE, lin_hdr_pkg::RST_TIMER_BYTE};
			hit_prev <= 1'b0;
		end else begin
			hit_prev <= hit_cond;
			if (on && cnt_clear) begin
				frame_idle_counter <= '0;
			end else if (on && I_BAUD_TICK && (frame_idle_counter != 16'hFFFF)) begin
				frame_idle_counter <= frame_idle_counter + 16'h0001;
			end
			if (wr_thi) begin
				counter_limit[15:8] <= wd;
			end
			if (wr_tlo) begin
				counter_limit[7:0] <= wd;
			end
		end
	end

	// ---------------------------------------------------------------
	// sticky flags, write zero clears, set wins
	// ---------------------------------------------------------------
	wire clr_hit = wr_flags && !wd[lin_hdr_pkg::BIT_LIMIT_HIT];
	wire clr_rx = wr_flags && !wd[lin_hdr_pkg::BIT_SYNC_RX];
	wire clr_done = wr_flags && !wd[lin_hdr_pkg::BIT_DONE];
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			counter_limit_hit <= 1'b0;
			sync_received_irq <= 1'b0;
			auto_sync_done_irq <= 1'b0;
		end else begin
			counter_limit_hit <= hit_evt || (counter_limit_hit && !clr_hit);
			sync_received_irq <= slave_sync || (sync_received_irq && !clr_rx);
			auto_sync_done_irq <= auto_upd || (auto_sync_done_irq && !clr_done);
		end
	end
	assign O_LIMIT_HIT = counter_limit_hit;
	assign O_SYNC_RECEIVED = sync_received_irq;
	assign O_SYNC_DONE = auto_sync_done_irq;

	// ---------------------------------------------------------------
	// read data, registered at address phase
	// ---------------------------------------------------------------
	wire [7:0] rd_ctrl = {ctrl.func_on, ctrl.master, 1'b0, ctrl.async_once, ctrl.break_req, ctrl.extra_len};
	wire [7:0] rd_flags = {4'h0, auto_sync_done_irq, 1'b0, sync_received_irq, counter_limit_hit};
	wire [31:0] rd_mux =
		(a_index == lin_hdr_pkg::IDX_CONTROL) ? {24'h000000, rd_ctrl} :
		(a_index == lin_hdr_pkg::IDX_TIMER_HIGH) ? {24'h000000, frame_idle_counter[15:8]} :
		(a_index == lin_hdr_pkg::IDX_TIMER_LOW) ? {24'h000000, frame_idle_counter[7:0]} :
		(a_index == lin_hdr_pkg::IDX_RATE) ? {16'h0000, measured_rate_divisor} :
		(a_index == lin_hdr_pkg::IDX_FLAGS) ? {24'h000000, rd_flags} : 32'h00000000;
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_HRDATA <= '0;
		end else if (take && !I_HWRITE) begin
			O_HRDATA <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_dom_run;
		brk_state == lin_hdr_pkg::BRK_DOMINANT;
	endsequence
	property p_no_break_when_off;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N) !on |-> !ctrl.break_req ##1 brk_state == lin_hdr_pkg::BRK_IDLE;
	endproperty
	a_no_break_when_off: assert property (p_no_break_when_off) else $error("break active while disabled");
	property p_master_locked;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N) $past(on) |-> ctrl.master == $past(ctrl.master);
	endproperty
	a_master_locked: assert property (p_master_locked) else $error("master select changed while on");
	property p_dom_len;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		(s_dom_run and I_BAUD_TICK) |-> brk_cnt < brk_len;
	endproperty
	a_dom_len: assert property (p_dom_len) else $error("dominant run too long");
	property p_delim_after_dom;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		brk_state == lin_hdr_pkg::BRK_DELIMIT |-> $past(brk_state) != lin_hdr_pkg::BRK_IDLE;
	endproperty
	a_delim_after_dom: assert property (p_delim_after_dom) else $error("delimiter without dominant");
	property p_break_clears;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N) brk_done && !brk_set |=> !ctrl.break_req;
	endproperty
	a_break_clears: assert property (p_break_clears) else $error("break bit not cleared");
	property p_auto_copy;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		auto_upd |=> rate_divisor == $past(I_SYNC.divisor) && auto_sync_done_irq;
	endproperty
	a_auto_copy: assert property (p_auto_copy) else $error("auto sync did not copy divisor");
	property p_no_auto_keep;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		slave_sync && !auto_upd && !wr_rate |=> $stable(rate_divisor) && sync_received_irq;
	endproperty
	a_no_auto_keep: assert property (p_no_auto_keep) else $error("divisor changed without auto sync");
	property p_once_clears;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		auto_upd && !ctrl.async_always && !wr_ctrl |=> !ctrl.async_once;
	endproperty
	a_once_clears: assert property (p_once_clears) else $error("one-shot sync not cleared");
	property p_master_hit;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		on && ctrl.master && (frame_idle_counter >= counter_limit) && !hit_prev |=> counter_limit_hit;
	endproperty
	a_master_hit: assert property (p_master_hit) else $error("limit flag missed");
	property p_break_clears_timer;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N) brk_start && ctrl.master |=> frame_idle_counter == 16'h0000;
	endproperty
	a_break_clears_timer: assert property (p_break_clears_timer) else $error("timer not cleared at break");
	property p_hit_sticky;
		@(posedge I_SYS_CLK) disable iff (!I_RESET_N) counter_limit_hit && !clr_hit |=> counter_limit_hit;
	endproperty
	a_hit_sticky: assert property (p_hit_sticky) else $error("limit flag dropped");

endmodule

// >>> hw/lin_hdr_pkg.sv
// constants and carriers shared by the header control block
package lin_hdr_pkg;
	// register indices; byte address is four times the index
	localparam logic [17:0] IDX_CONTROL = 18'h0A090;
	localparam logic [17:0] IDX_TIMER_HIGH = 18'h0A091;
	localparam logic [17:0] IDX_TIMER_LOW = 18'h0A092;
	localparam logic [17:0] IDX_RATE = 18'h0A093;
	localparam logic [17:0] IDX_FLAGS = 18'h0A095;
	// control field positions
	localparam int BIT_FUNC_ON = 7;
	localparam int BIT_MASTER = 6;
	localparam int BIT_ASYNC_ALWAYS = 5;
	localparam int BIT_ASYNC_ONCE = 4;
	localparam int BIT_BREAK_REQ = 3;
	localparam int BIT_EXTRA_HI = 2;
	// flag field positions
	localparam int BIT_DONE = 3;
	localparam int BIT_SYNC_RX = 1;
	localparam int BIT_LIMIT_HIT = 0;
	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_TIMER_BYTE = 8'hFF;
	localparam logic [15:0] RST_RATE = 16'h0000;
	// break length in bit times
	localparam logic [4:0] BREAK_BASE_BITS = 5'h0D;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic valid;
		logic [15:0] divisor;
	} sync_meas_t;

	typedef struct packed {
		logic func_on;
		logic master;
		logic async_always;
		logic async_once;
		logic break_req;
		logic [2:0] extra_len;
	} control_t;

	typedef enum logic [1:0] {
		BRK_IDLE = 2'b00,
		BRK_ALIGN = 2'b01,
		BRK_DOMINANT = 2'b10,
		BRK_DELIMIT = 2'b11
	} brk_state_t;
endpackage

// >>> verif/lin_bus_node_model.sv
// far-side lin node model: pulled-up shared wire and sync measurement pulses
`timescale 1ns/1ps
module lin_bus_node_model (
	// clock
	input wire logic i_clk,
	// local transmitter view
	input wire logic i_tx_override,
	input wire logic i_tx_level,
	// far node commands
	input wire logic i_drive_dom,
	input wire logic i_sync_send,
	input wire logic [15:0] i_sync_div,
	// bus view
	output logic o_rx_pin,
	output lin_hdr_pkg::sync_meas_t o_sync
);
	// ---------------------------------------------
	// wire and measurement
	// ---------------------------------------------
	logic [15:0] last_div = 16'h0000;
	// pull-up wins unless some party drives dominant; edges feed the idle timer
	assign o_rx_pin = ~i_drive_dom & (i_tx_override ? i_tx_level : 1'b1);
	// divisor only meaningful with valid, so it moves otherwise
	assign o_sync.valid = i_sync_send;
	assign o_sync.divisor = i_sync_send ? i_sync_div : ~last_div;
	always_ff @(posedge i_clk) begin
		last_div <= o_sync.divisor;
	end
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the header control block
`timescale 1ns/1ps
module tb_top;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic baud_tick = 1'b0;
	logic [1:0] tick_cnt = 2'h0;
	logic drive_dom = 1'b0;
	logic sync_send = 1'b0;
	logic [15:0] sync_div = 16'h0000;
	logic hreadyout, hresp, rx_pin, tx_ovr, tx_lvl, lim_hit, sync_rx, sync_done;
	logic [31:0] hrdata;
	logic [15:0] rate_div;
	lin_hdr_pkg::sync_meas_t sync;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;
	int dom_cyc = 0;
	int del_cyc = 0;

	lin_header_control_and_frame_timer dut_u (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
		.I_HREADY(hreadyout), .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .O_HRDATA(hrdata),
		.I_BAUD_TICK(baud_tick), .I_RX_PIN(rx_pin), .I_SYNC(sync), .O_TX_OVERRIDE(tx_ovr),
		.O_TX_LEVEL(tx_lvl), .O_RATE_DIVISOR(rate_div), .O_LIMIT_HIT(lim_hit),
		.O_SYNC_RECEIVED(sync_rx), .O_SYNC_DONE(sync_done));

	lin_bus_node_model node_u (.i_clk(clk), .i_tx_override(tx_ovr), .i_tx_level(tx_lvl),
		.i_drive_dom(drive_dom), .i_sync_send(sync_send), .i_sync_div(sync_div),
		.o_rx_pin(rx_pin), .o_sync(sync));

	// ---------------------------------------------
	// clock, baud tick, monitor, timeout
	// ---------------------------------------------
	always #4 clk = ~clk;
	// bit time of four clocks keeps breaks short
	always @(posedge clk) begin
		tick_cnt <= tick_cnt + 2'h1;
		baud_tick <= (tick_cnt == 2'h3);
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (tx_ovr === 1'b1 && tx_lvl === 1'b0) dom_cyc <= dom_cyc + 1;
		if (tx_ovr === 1'b1 && tx_lvl === 1'b1) del_cyc <= del_cyc + 1;
		if (cycles == 20000) begin
			err_total++;
			close_out();
		end
	end

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task automatic close_out();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic xfer(input logic wr, input logic [17:0] idx, input logic [15:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= lin_hdr_pkg::HTRANS_NONSEQ;
		haddr <= {12'h000, idx, 2'b00};
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, wd};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [17:0] idx, input logic [15:0] d);
		logic [31:0] unused;
		xfer(1'b1, idx, d, unused);
	endtask
	task automatic rdc(input string name, input logic [17:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		xfer(1'b0, idx, 16'h0000, v);
		chk(name, v, exp);
	endtask
	task automatic ticks(input int n);
		repeat (n * 4) @(posedge clk);
	endtask
	task automatic pulse_sync(input logic [15:0] d);
		@(posedge clk);
		sync_send <= 1'b1;
		sync_div <= d;
		@(posedge clk);
		sync_send <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic wait_brk();
		logic [31:0] v;
		int n;
		n = 0;
		v = 32'h8;
		while (v[3] !== 1'b0 && n < 100) begin
			xfer(1'b0, lin_hdr_pkg::IDX_CONTROL, 16'h0000, v);
			n++;
		end
		chk("break bit", {31'h0, v[3]}, 32'h0);
	endtask

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_reset();
		rdc("control", lin_hdr_pkg::IDX_CONTROL, 32'h00);
		rdc("timer high", lin_hdr_pkg::IDX_TIMER_HIGH, 32'hFF);
		rdc("timer low", lin_hdr_pkg::IDX_TIMER_LOW, 32'hFF);
		wr(18'h0A09F, 16'h00FF);
		rdc("unmapped", 18'h0A09F, 32'h0);
		chk("okay", {31'h0, hresp}, 32'h0);
		chk("override", {31'h0, tx_ovr}, 32'h0);
	endtask
	task automatic t_break(input logic [2:0] bl);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0040);
		dom_cyc <= 0;
		del_cyc <= 0;
		wr(lin_hdr_pkg::IDX_CONTROL, {8'h00, 5'b11001, bl});
		wr(lin_hdr_pkg::IDX_CONTROL, {8'h00, 5'b11000, bl});
		rdc("break sticky", lin_hdr_pkg::IDX_CONTROL, {24'h0, 5'b11001, bl});
		wait_brk();
		chk("dominant", dom_cyc, (13 + bl) * 4);
		chk("delimiter", del_cyc, 4);
		rdc("timer cleared", lin_hdr_pkg::IDX_TIMER_HIGH, 32'h0);
	endtask
	task automatic t_abort();
		int n;
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h00C8);
		for (n = 0; n < 40 && tx_ovr !== 1'b1; n++) @(posedge clk);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0040);
		@(posedge clk);
		#1;
		chk("abort", {31'h0, tx_ovr}, 32'h0);
		rdc("abort bit", lin_hdr_pkg::IDX_CONTROL, 32'h40);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0048);
		ticks(3);
		chk("off break", {31'h0, tx_ovr}, 32'h0);
	endtask
	task automatic t_sync();
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0000);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0080);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h00C0);
		rdc("role held", lin_hdr_pkg::IDX_CONTROL, 32'h80);
		wr(lin_hdr_pkg::IDX_RATE, 16'h0042);
		wr(lin_hdr_pkg::IDX_FLAGS, 16'h0000);
		chk("rate", rate_div, 32'h0042);
		pulse_sync(16'h1234);
		chk("sync rx", {31'h0, sync_rx}, 32'h1);
		chk("no done", {31'h0, sync_done}, 32'h0);
		chk("rate kept", rate_div, 32'h0042);
		rdc("measured", lin_hdr_pkg::IDX_RATE, 32'h1234);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0090);
		pulse_sync(16'h0456);
		chk("once rate", rate_div, 32'h0456);
		chk("once done", {31'h0, sync_done}, 32'h1);
		rdc("once clear", lin_hdr_pkg::IDX_CONTROL, 32'h80);
		pulse_sync(16'h0789);
		chk("once only", rate_div, 32'h0456);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h00A0);
		pulse_sync(16'h0111);
		chk("always 1", rate_div, 32'h0111);
		pulse_sync(16'h0222);
		chk("always 2", rate_div, 32'h0222);
		wr(lin_hdr_pkg::IDX_FLAGS, 16'h0000);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0000);
		pulse_sync(16'h0333);
		chk("off sync", {31'h0, sync_rx}, 32'h0);
		chk("off rate", rate_div, 32'h0222);
	endtask
	task automatic t_master_timer();
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0040);
		wr(lin_hdr_pkg::IDX_TIMER_HIGH, 16'h0000);
		wr(lin_hdr_pkg::IDX_TIMER_LOW, 16'h0014);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h00C8);
		wait_brk();
		wr(lin_hdr_pkg::IDX_FLAGS, 16'h0000);
		#1;
		chk("below limit", {31'h0, lim_hit}, 32'h0);
		ticks(12);
		chk("limit hit", {31'h0, lim_hit}, 32'h1);
		wr(lin_hdr_pkg::IDX_FLAGS, 16'h0000);
		ticks(2);
		chk("one event", {31'h0, lim_hit}, 32'h0);
	endtask
	task automatic t_slave_timer();
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0000);
		wr(lin_hdr_pkg::IDX_CONTROL, 16'h0080);
		wr(lin_hdr_pkg::IDX_TIMER_LOW, 16'h0008);
		drive_dom <= 1'b1;
		ticks(1);
		wr(lin_hdr_pkg::IDX_FLAGS, 16'h0000);
		repeat (6) begin
			drive_dom <= ~drive_dom;
			ticks(4);
		end
		chk("busy bus", {31'h0, lim_hit}, 32'h0);
		drive_dom <= 1'b0;
		ticks(12);
		chk("idle bus", {31'h0, lim_hit}, 32'h1);
	endtask

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_break(3'h0);
		t_break(3'h7);
		t_abort();
		t_sync();
		t_master_timer();
		t_slave_timer();
		close_out();
	end
endmodule
